//--- logic/lcdc_defines.vh
// Purpose: Constants for the LCD command decoder and cascade alignment block.
// Assumes: Command bytes arrive whole from an I2C slave front end.
// Notes: Definitions only; included by bare name.
`ifndef LCDC_DEFINES_VH
`define LCDC_DEFINES_VH

// ==========================================================
// Command byte fields
`define LCDC_MORE_BIT 7
`define LCDC_PTR_MSB 5
`define LCDC_OP_CFG 2'h2
`define LCDC_OP_CHIP 4'hC
`define LCDC_OP_FLASH 4'hE
`define LCDC_OP_HALF 5'h1E
`define LCDC_CFG_HALFBIAS 2
`define LCDC_CFG_DISPON 3
`define LCDC_CFG_LOWPWR 4
`define LCDC_HALF_STORE 1
`define LCDC_HALF_FETCH 0
`define LCDC_FLASH_KIND 2

// ==========================================================
// Drive selections (drive_sel_hi, drive_sel_lo)
`define LCDC_DRV_STATIC 2'h1
`define LCDC_DRV_MUX2 2'h2
`define LCDC_DRV_MUX3 2'h3
`define LCDC_DRV_MUX4 2'h0

// ==========================================================
// Reset values of the held settings
`define LCDC_RST_DRV 2'h0
`define LCDC_RST_PTR 6'h00
`define LCDC_RST_SUB 3'h0
`define LCDC_RST_RATE 2'h0

// ==========================================================
// Display RAM geometry and pointer steps per byte
`define LCDC_RAM_LAST 6'h27
`define LCDC_RAM_SIZE 7'h28
`define LCDC_STEP_STATIC 7'h08
`define LCDC_STEP_MUX2 7'h04
`define LCDC_STEP_MUX3 7'h03
`define LCDC_STEP_MUX4 7'h02

// ==========================================================
// Backplane phase numbers
`define LCDC_PH_LAST_STATIC 2'h1
`define LCDC_PH_LAST_MUX2 2'h1
`define LCDC_PH_LAST_MUX3 2'h2
`define LCDC_PH_LAST_MUX4 2'h3
`define LCDC_PH_FIRST 2'h0

// ==========================================================
// Flash period in link clocks for the fastest rate
`define LCDC_FLASH_NORM 92160
`define LCDC_FLASH_LP 15360

`endif

//--- logic/lcdc_top.v
// Purpose: Command decoder, display controller and cascade alignment for a segment LCD driver.
// Assumes: Bytes come from an I2C slave front end on i_clk; the link clock and pins are async.
// Notes: A 16-word FIFO buffers bytes; the RAM write port can stall it.
//
// Summary of operation
// - Bits 6:5 = 10 set drive selection
// - Config bit 2 picks half or third bias
// - Config bit 3 blanks or enables display
// - Config bit 4 selects power-saving mode
// - Bit 6 clear loads RAM data pointer
// - Bits 6:3 = 1100 load subaddress counter
// - Half pick bit 1 chooses storage half
// - Half pick bit 0 chooses display half
// - Half pick ignored in 1:3 and 1:4
// - Bits 6:3 = 1110 set flash rate
// - Flash bit 2 selects blank or alternation
// - No alternation flashing in 1:3 or 1:4
// - Controller holds settings and writes display bytes
// - Subaddress plus address pin give sixteen devices
// - Drive align line in last phase, else sample
// - Align line is open drain, low only
// - Realign to first align assertion seen
// - Reset starts all devices aligned
// - Bit 7 set means another command follows
// - Pointer advances; only matching subaddress stores
`timescale 1ns/100ps
`include "lcdc_defines.vh"

// ==========================================================
// Byte FIFO
module lcdc_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_in_ready,
  output wire o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wptr_ff;
  reg [AW:0] rptr_ff;
  wire full;
  wire empty;
  wire push;
  wire pop;

  // Extra pointer bit tells full from empty
  assign empty = (wptr_ff == rptr_ff);
  assign full = (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]) && (wptr_ff[AW] != rptr_ff[AW]);
  assign o_in_ready = ~full;
  assign o_out_valid = ~empty;
  assign o_out_data = mem[rptr_ff[AW-1:0]];
  assign push = i_in_valid & ~full;
  assign pop = i_out_ready & ~empty;

  // Storage has no reset; only pointers matter
  always @(posedge i_clk) begin
    if (push) begin
      mem[wptr_ff[AW-1:0]] <= i_in_data;
    end
  end

  // Pointers
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wptr_ff <= {(AW+1){1'b0}};
      rptr_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= rptr_ff + 1'b1;
      end
    end
  end
endmodule // lcdc_fifo

// ==========================================================
// Decoder, controller and cascade alignment
module lcdc_top #(
  parameter FIFO_DEPTH = 16,
  parameter FLASH_NORM = `LCDC_FLASH_NORM,
  parameter FLASH_LP = `LCDC_FLASH_LP
) (
  input wire i_clk,
  input wire i_rst,
  // Byte stream from the I2C front end
  input wire i_byte_valid,
  input wire [7:0] i_byte,
  input wire i_byte_first,
  output wire o_byte_ready,
  output wire o_data_ack,
  // Display RAM write port
  input wire i_ram_ready,
  output wire o_ram_wr,
  output wire [5:0] o_ram_addr,
  output wire [7:0] o_ram_wdata,
  output wire o_ram_half,
  // Held settings
  output wire [1:0] o_drive_sel,
  output wire o_half_bias,
  output wire o_display_on,
  output wire o_low_power,
  output wire o_storage_half,
  output wire o_fetch_half,
  output wire [1:0] o_flash_rate,
  output wire o_flip_kind,
  output wire [2:0] o_sub_counter,
  output wire [5:0] o_ram_pointer,
  // Effective display controls after flashing
  output wire o_display_show,
  output wire o_display_half,
  // Device identity for the front end
  output wire [3:0] o_dev_id,
  // Pins
  input wire [2:0] i_chip_subaddress,
  input wire i_bus_addr_low_pin,
  input wire i_link_clk,
  input wire i_align_in,
  output wire o_align_out,
  output wire o_align_oe,
  output wire [1:0] o_bp_phase
);
  // Pin synchronisers: bit 0 link clock, 1 align, 4:2 subaddress, 5 address pin
  reg [5:0] pin_s1_ff;
  reg [5:0] pin_s2_ff;
  reg link_d_ff;
  reg align_d_ff;
  // Settings
  reg [1:0] drv_ff;
  reg half_bias_ff;
  reg disp_on_ff;
  reg low_pwr_ff;
  reg store_half_ff;
  reg fetch_half_ff;
  reg [1:0] rate_ff;
  reg flip_kind_ff;
  reg [2:0] sub_ff;
  reg [5:0] ptr_ff;
  reg cmd_mode_ff;
  // RAM write register
  reg ram_wr_ff;
  reg [5:0] ram_addr_ff;
  reg [7:0] ram_wdata_ff;
  reg ram_half_ff;
  reg ack_ff;
  // Backplane and flashing
  reg [1:0] phase_ff;
  reg align_oe_ff;
  reg [19:0] flash_cnt_ff;
  reg flash_ph_ff;
  // Next values
  reg [1:0] nxt_drv;
  reg nxt_half_bias;
  reg nxt_disp_on;
  reg nxt_low_pwr;
  reg nxt_store_half;
  reg nxt_fetch_half;
  reg [1:0] nxt_rate;
  reg nxt_flip_kind;
  reg [2:0] nxt_sub;
  reg [5:0] nxt_ptr;
  reg nxt_cmd_mode;
  reg nxt_ram_wr;
  reg nxt_ack;
  reg [6:0] step;
  reg [6:0] ptr_sum;
  reg [6:0] ptr_wrap;
  reg [1:0] ph_last;

  wire f_valid;
  wire [8:0] f_data;
  wire take;
  wire is_cmd;
  wire [7:0] b;
  wire link_edge;
  wire align_fall;
  wire mux_low;
  wire sub_match;
  wire [19:0] flash_lim;

  // ==========================================================
  // Input buffering; a busy RAM port stalls the drain and backs up the source
  lcdc_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH),
    .AW(4)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(i_byte_valid),
    .i_in_data({i_byte_first, i_byte}),
    .o_in_ready(o_byte_ready),
    .o_out_valid(f_valid),
    .o_out_data(f_data),
    .i_out_ready(i_ram_ready)
  );

  assign take = f_valid & i_ram_ready;
  assign b = f_data[7:0];
  // A first byte of a transfer is always a command
  assign is_cmd = cmd_mode_ff | f_data[8];
  // Only static and 1:2 have two RAM halves
  assign mux_low = (drv_ff == `LCDC_DRV_STATIC) || (drv_ff == `LCDC_DRV_MUX2);
  assign sub_match = (sub_ff == pin_s2_ff[4:2]);

  // ==========================================================
  // Pin synchronisers; stage one feeds only stage two
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_ff <= 6'h03;
      pin_s2_ff <= 6'h03;
      link_d_ff <= 1'b1;
      align_d_ff <= 1'b1;
    end else begin
      pin_s1_ff <= {i_bus_addr_low_pin, i_chip_subaddress, i_align_in, i_link_clk};
      pin_s2_ff <= pin_s1_ff;
      link_d_ff <= pin_s2_ff[0];
      align_d_ff <= pin_s2_ff[1];
    end
  end

  assign link_edge = pin_s2_ff[0] & ~link_d_ff;
  assign align_fall = ~pin_s2_ff[1] & align_d_ff;

  // ==========================================================
  // Pointer step per display byte, by drive selection
  always @* begin
    case (drv_ff)
      `LCDC_DRV_STATIC: step = `LCDC_STEP_STATIC;
      `LCDC_DRV_MUX2: step = `LCDC_STEP_MUX2;
      `LCDC_DRV_MUX3: step = `LCDC_STEP_MUX3;
      default: step = `LCDC_STEP_MUX4;
    endcase
    ptr_sum = {1'b0, ptr_ff} + step;
    // Wrap on the full sum; pointers loaded above 39 would go wrong from six bits
    ptr_wrap = ptr_sum - `LCDC_RAM_SIZE;
  end

  // ==========================================================
  // Command decode and display byte handling
  always @* begin
    nxt_drv = drv_ff;
    nxt_half_bias = half_bias_ff;
    nxt_disp_on = disp_on_ff;
    nxt_low_pwr = low_pwr_ff;
    nxt_store_half = store_half_ff;
    nxt_fetch_half = fetch_half_ff;
    nxt_rate = rate_ff;
    nxt_flip_kind = flip_kind_ff;
    nxt_sub = sub_ff;
    nxt_ptr = ptr_ff;
    nxt_cmd_mode = cmd_mode_ff;
    nxt_ram_wr = 1'b0;
    nxt_ack = 1'b0;
    if (take && is_cmd) begin
      nxt_cmd_mode = b[`LCDC_MORE_BIT];
      if (!b[6]) begin
        nxt_ptr = b[`LCDC_PTR_MSB:0];
      end else if (b[6:5] == `LCDC_OP_CFG) begin
        nxt_drv = b[1:0];
        nxt_half_bias = b[`LCDC_CFG_HALFBIAS];
        nxt_disp_on = b[`LCDC_CFG_DISPON];
        nxt_low_pwr = b[`LCDC_CFG_LOWPWR];
      end else if (b[6:3] == `LCDC_OP_CHIP) begin
        nxt_sub = b[2:0];
      end else if (b[6:3] == `LCDC_OP_FLASH) begin
        nxt_rate = b[1:0];
        nxt_flip_kind = b[`LCDC_FLASH_KIND];
      end else if ((b[6:2] == `LCDC_OP_HALF) && mux_low) begin
        nxt_store_half = b[`LCDC_HALF_STORE];
        nxt_fetch_half = b[`LCDC_HALF_FETCH];
      end
      // Remaining patterns fall through untouched
    end else if (take) begin
      // Display byte: store only on a subaddress match, always advance
      nxt_ram_wr = sub_match;
      nxt_ack = sub_match;
      if (ptr_sum >= `LCDC_RAM_SIZE) begin
        nxt_ptr = ptr_wrap[5:0];
        nxt_sub = sub_ff + 3'h1;
      end else begin
        nxt_ptr = ptr_sum[5:0];
      end
    end
  end

  // Settings and RAM write registers
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      drv_ff <= `LCDC_RST_DRV;
      half_bias_ff <= 1'b0;
      disp_on_ff <= 1'b0;
      low_pwr_ff <= 1'b0;
      store_half_ff <= 1'b0;
      fetch_half_ff <= 1'b0;
      rate_ff <= `LCDC_RST_RATE;
      flip_kind_ff <= 1'b0;
      sub_ff <= `LCDC_RST_SUB;
      ptr_ff <= `LCDC_RST_PTR;
      cmd_mode_ff <= 1'b1;
      ram_wr_ff <= 1'b0;
      ram_addr_ff <= `LCDC_RST_PTR;
      ram_wdata_ff <= 8'h00;
      ram_half_ff <= 1'b0;
      ack_ff <= 1'b0;
    end else begin
      drv_ff <= nxt_drv;
      half_bias_ff <= nxt_half_bias;
      disp_on_ff <= nxt_disp_on;
      low_pwr_ff <= nxt_low_pwr;
      store_half_ff <= nxt_store_half;
      fetch_half_ff <= nxt_fetch_half;
      rate_ff <= nxt_rate;
      flip_kind_ff <= nxt_flip_kind;
      sub_ff <= nxt_sub;
      ptr_ff <= nxt_ptr;
      cmd_mode_ff <= nxt_cmd_mode;
      ram_wr_ff <= nxt_ram_wr;
      ack_ff <= nxt_ack;
      if (nxt_ram_wr) begin
        ram_addr_ff <= ptr_ff;
        ram_wdata_ff <= b;
        ram_half_ff <= store_half_ff & mux_low;
      end
    end
  end

  // ==========================================================
  // Backplane phase: last phase index per drive selection
  always @* begin
    case (drv_ff)
      `LCDC_DRV_STATIC: ph_last = `LCDC_PH_LAST_STATIC;
      `LCDC_DRV_MUX2: ph_last = `LCDC_PH_LAST_MUX2;
      `LCDC_DRV_MUX3: ph_last = `LCDC_PH_LAST_MUX3;
      default: ph_last = `LCDC_PH_LAST_MUX4;
    endcase
  end

  // Phase counter and align line drive; reset puts every device at phase zero
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_ff <= `LCDC_PH_FIRST;
      align_oe_ff <= 1'b0;
    end else begin
      if (!align_oe_ff && align_fall && (phase_ff != ph_last)) begin
        // Another device entered its last phase first: join it; this wins over a
        // coincident display clock edge, as a sibling's pull lands on one
        phase_ff <= ph_last;
        align_oe_ff <= 1'b1;
      end else if (link_edge) begin
        if (phase_ff >= ph_last) begin
          phase_ff <= `LCDC_PH_FIRST;
        end else begin
          phase_ff <= phase_ff + 2'h1;
        end
        // Pull the line low during our last phase only
        align_oe_ff <= (phase_ff == ph_last - 2'h1);
      end
    end
  end

  // ==========================================================
  // Flash timer on link clocks; half period of the chosen rate
  assign flash_lim = (low_pwr_ff ? FLASH_LP[19:0] : FLASH_NORM[19:0]) >> 1 << (rate_ff - 2'h1);

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flash_cnt_ff <= 20'h00000;
      flash_ph_ff <= 1'b0;
    end else if (rate_ff == 2'h0) begin
      flash_cnt_ff <= 20'h00000;
      flash_ph_ff <= 1'b0;
    end else if (link_edge) begin
      if (flash_cnt_ff >= flash_lim - 20'h00001) begin
        flash_cnt_ff <= 20'h00000;
        flash_ph_ff <= ~flash_ph_ff;
      end else begin
        flash_cnt_ff <= flash_cnt_ff + 20'h00001;
      end
    end
  end

  // ==========================================================
  // Output assignments
  assign o_ram_wr = ram_wr_ff;
  assign o_ram_addr = ram_addr_ff;
  assign o_ram_wdata = ram_wdata_ff;
  assign o_ram_half = ram_half_ff;
  assign o_data_ack = ack_ff;
  assign o_drive_sel = drv_ff;
  assign o_half_bias = half_bias_ff;
  assign o_display_on = disp_on_ff;
  assign o_low_power = low_pwr_ff;
  assign o_storage_half = store_half_ff;
  assign o_fetch_half = fetch_half_ff;
  assign o_flash_rate = rate_ff;
  assign o_flip_kind = flip_kind_ff;
  assign o_sub_counter = sub_ff;
  assign o_ram_pointer = ptr_ff;
  // Blank-style flashing gates the display; alternation needs two halves
  assign o_display_show = disp_on_ff & ~(flash_ph_ff & ~flip_kind_ff);
  assign o_display_half = (fetch_half_ff ^ (flash_ph_ff & flip_kind_ff)) & mux_low;
  assign o_dev_id = {pin_s2_ff[5], pin_s2_ff[4:2]};
  // Open drain: data is always low, only the enable moves
  assign o_align_out = 1'b0;
  assign o_align_oe = align_oe_ff;
  assign o_bp_phase = phase_ff;
endmodule // lcdc_top

//--- testbench/lcdc_top_asserts.sv
// Purpose: Port-level checks for the LCD command decoder.
// Assumes: One i_clk domain with async active-high reset.
// Notes: Bound into every lcdc_top instance.
`timescale 1ns/100ps

// ====================
// Checker
module lcdc_top_asserts (
  input logic i_clk,
  input logic i_rst,
  input logic o_ram_wr,
  input logic o_data_ack,
  input logic o_ram_half,
  input logic [1:0] o_drive_sel,
  input logic o_display_on,
  input logic o_storage_half,
  input logic o_fetch_half,
  input logic [1:0] o_flash_rate,
  input logic o_display_show,
  input logic o_display_half,
  input logic [3:0] o_dev_id,
  input logic [2:0] i_chip_subaddress,
  input logic i_bus_addr_low_pin,
  input logic o_align_out,
  input logic o_align_oe,
  input logic [1:0] o_bp_phase
);
  logic [2:0] up_ff;
  logic [5:0] age_ff;
  logic [1:0] sel_ff;
  logic [1:0] last_ph;
  logic mux34;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Last phase per drive mode; static counts as two phases
  assign mux34 = (o_drive_sel == 2'h3) || (o_drive_sel == 2'h0);
  assign last_ph = (o_drive_sel == 2'h3) ? 2'h2 : (o_drive_sel == 2'h0) ? 2'h3 : 2'h1;
  // Ages since reset and since a drive change; a mode switch may leave
  // a stale phase on the line logic for a while
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      up_ff <= 3'h0;
      age_ff <= 6'h00;
      sel_ff <= 2'h0;
    end else begin
      sel_ff <= o_drive_sel;
      if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
      if (sel_ff != o_drive_sel) age_ff <= 6'h00;
      else if (age_ff != 6'h3F) age_ff <= age_ff + 6'h01;
    end
  end
  property p_out_low; o_align_out == 1'b0; endproperty
  a_out_low: assert property (p_out_low) else $error("align pin drives high");
  property p_wr_ack; o_ram_wr == o_data_ack; endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write and ack differ");
  property p_wr_half; o_ram_wr |-> o_ram_half == (!mux34 && o_storage_half); endproperty
  a_wr_half: assert property (p_wr_half) else $error("write half wrong");
  property p_oe_phase; o_align_oe && age_ff == 6'h3F |-> o_bp_phase == last_ph; endproperty
  a_oe_phase: assert property (p_oe_phase) else $error("align drive off phase");
  property p_half34; mux34 |-> !o_display_half; endproperty
  a_half34: assert property (p_half34) else $error("alternation in 1:3/1:4");
  property p_show_off; !o_display_on |-> !o_display_show; endproperty
  a_show_off: assert property (p_show_off) else $error("shown while disabled");
  property p_flash_off; o_flash_rate == 2'h0 && $stable(o_flash_rate)
    |-> o_display_show == o_display_on && (mux34 || o_display_half == o_fetch_half); endproperty
  a_flash_off: assert property (p_flash_off) else $error("flashing while off");
  property p_dev_id; (up_ff == 3'h7 && $stable({i_bus_addr_low_pin, i_chip_subaddress}))[*5]
    |-> o_dev_id == {i_bus_addr_low_pin, i_chip_subaddress}; endproperty
  a_dev_id: assert property (p_dev_id) else $error("device id wrong");
  c_wr: cover property (o_ram_wr);
  c_align: cover property ($rose(o_align_oe));
  c_blank: cover property (o_display_on && !o_display_show);
endmodule // lcdc_top_asserts

bind lcdc_top lcdc_top_asserts lcdc_top_asserts_i (.i_clk(i_clk), .i_rst(i_rst),
  .o_ram_wr(o_ram_wr), .o_data_ack(o_data_ack), .o_ram_half(o_ram_half),
  .o_drive_sel(o_drive_sel), .o_display_on(o_display_on), .o_storage_half(o_storage_half),
  .o_fetch_half(o_fetch_half), .o_flash_rate(o_flash_rate), .o_display_show(o_display_show),
  .o_display_half(o_display_half), .o_dev_id(o_dev_id), .i_chip_subaddress(i_chip_subaddress),
  .i_bus_addr_low_pin(i_bus_addr_low_pin), .o_align_out(o_align_out),
  .o_align_oe(o_align_oe), .o_bp_phase(o_bp_phase));

//--- testbench/lcdc_peer_model.sv
// Purpose: Cascaded sibling driver on the shared align line and display clock.
// Assumes: Line has a pull-up; sibling only pulls low.
// Notes: Pull is held one full display clock period.
`timescale 1ns/100ps

// ====================
// Sibling model
module lcdc_peer_model (
  input logic i_pull,
  input logic i_dev_oe,
  output logic o_link_clk,
  output logic o_line
);
  logic pull_ff = 1'b0;
  logic req_ff = 1'b0;
  // Free-running display clock, phase unrelated to i_clk
  initial begin
    o_link_clk = 1'b0;
    #3.0;
    forever #16.0 o_link_clk = ~o_link_clk;
  end
  // Request seen any time, served at the next display clock edge
  always @(posedge i_pull or posedge pull_ff) begin
    req_ff <= i_pull;
  end
  always @(posedge o_link_clk) begin
    pull_ff <= req_ff && !pull_ff;
  end
  // Open drain with pull-up: any party pulling wins
  assign o_line = ~(pull_ff | i_dev_oe);
endmodule // lcdc_peer_model

//--- testbench/lcdc_top_tb.sv
// Purpose: Self-checking bench for the LCD command decoder.
// Assumes: Short flash periods set by parameter.
// Notes: Writes are checked against a queue of expected writes.
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; $display("mismatch %s exp %h got %h", n, e, a); end end

// ====================
// Bench
module lcdc_top_tb;
  logic i_clk, i_rst, i_byte_valid, i_byte_first, i_ram_ready, i_bus_addr_low_pin, pull, line;
  logic o_byte_ready, o_data_ack, o_ram_wr, o_ram_half, o_half_bias, o_display_on;
  logic o_low_power, o_storage_half, o_fetch_half, o_flip_kind, o_display_show;
  logic o_display_half, o_align_out, o_align_oe, link_clk;
  logic [7:0] i_byte, o_ram_wdata, d;
  logic [2:0] i_chip_subaddress, o_sub_counter;
  logic [5:0] o_ram_addr, o_ram_pointer;
  logic [1:0] o_drive_sel, o_flash_rate, o_bp_phase;
  logic [3:0] o_dev_id;
  logic [14:0] exp_q[$];
  logic [14:0] e;
  int mismatches, checks_done, seed, cyc, n;

  lcdc_top #(.FIFO_DEPTH(16), .FLASH_NORM(8), .FLASH_LP(4)) lcdc_top_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_byte_valid(i_byte_valid), .i_byte(i_byte),
    .i_byte_first(i_byte_first), .o_byte_ready(o_byte_ready), .o_data_ack(o_data_ack),
    .i_ram_ready(i_ram_ready), .o_ram_wr(o_ram_wr), .o_ram_addr(o_ram_addr),
    .o_ram_wdata(o_ram_wdata), .o_ram_half(o_ram_half), .o_drive_sel(o_drive_sel),
    .o_half_bias(o_half_bias), .o_display_on(o_display_on), .o_low_power(o_low_power),
    .o_storage_half(o_storage_half), .o_fetch_half(o_fetch_half),
    .o_flash_rate(o_flash_rate), .o_flip_kind(o_flip_kind), .o_sub_counter(o_sub_counter),
    .o_ram_pointer(o_ram_pointer), .o_display_show(o_display_show),
    .o_display_half(o_display_half), .o_dev_id(o_dev_id),
    .i_chip_subaddress(i_chip_subaddress), .i_bus_addr_low_pin(i_bus_addr_low_pin),
    .i_link_clk(link_clk), .i_align_in(line), .o_align_out(o_align_out),
    .o_align_oe(o_align_oe), .o_bp_phase(o_bp_phase));
  lcdc_peer_model lcdc_peer_model_i (.i_pull(pull), .i_dev_oe(o_align_oe),
    .o_link_clk(link_clk), .o_line(line));

  // ====================
  // Clock, timeout and verdict
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Offer a byte and hold it until the FIFO takes it; valid stays up
  task automatic send(input logic [7:0] b, input logic f);
    int w;
    w = 0;
    i_byte <= b;
    i_byte_first <= f;
    i_byte_valid <= 1'b1;
    do begin @(posedge i_clk); w++; end while (o_byte_ready !== 1'b1 && w < 500);
  endtask
  task automatic idle(input int c);
    i_byte_valid <= 1'b0;
    repeat (c) @(posedge i_clk);
  endtask

  // Each write takes the oldest note; an unexpected write meets x
  always @(posedge i_clk) begin
    if (o_ram_wr === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 15'hx;
      `CHK("ram write", e, {o_ram_half, o_ram_addr, o_ram_wdata})
      `CHK("data ack", 1'b1, o_data_ack)
    end
  end

  // ====================
  // Main sequence
  initial begin
    seed = 32'h5598;
    i_rst = 1'b1;
    i_byte_valid = 1'b0;
    i_byte = 8'h00;
    i_byte_first = 1'b0;
    i_ram_ready = 1'b1;
    i_chip_subaddress = 3'h0;
    i_bus_addr_low_pin = 1'b1;
    pull = 1'b0;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    `CHK("drive", 2'h0, o_drive_sel)
    `CHK("ready", 1'b1, o_byte_ready)
    `CHK("dev id", 4'h8, o_dev_id)
    // Every drive mode, with random bias, enable and power bits
    for (int m = 0; m < 4; m++) begin
      d = {3'h6, 3'($random(seed)), 2'(m)};
      send(d, m == 0);
      idle(4);
      `CHK("drive", d[1:0], o_drive_sel)
      `CHK("bias", d[2], o_half_bias)
      `CHK("enable", d[3], o_display_on)
      `CHK("low power", d[4], o_low_power)
    end
    send(8'hC9, 1'b0);
    for (int k = 0; k < 8; k++) begin
      d = 8'hF0 | 8'(k);
      send(d, 1'b0);
      idle(4);
      `CHK("rate", d[1:0], o_flash_rate)
      `CHK("kind", d[2], o_flip_kind)
    end
    // Blank flashing, then alternation, then alternation barred in 1:4
    send(8'hF1, 1'b0);
    idle(2);
    n = 0;
    while (o_display_show !== 1'b0 && n < 300) begin @(posedge i_clk); n++; end
    `CHK("blank", 1'b0, o_display_show)
    send(8'hF5, 1'b0);
    idle(2);
    n = 0;
    while (o_display_half !== 1'b1 && n < 300) begin @(posedge i_clk); n++; end
    `CHK("alt half", 1'b1, o_display_half)
    send(8'hC8, 1'b0);
    send(8'hF9, 1'b0);
    idle(4);
    `CHK("alt 1:4", 1'b0, o_display_half)
    `CHK("fetch", 1'b0, o_fetch_half)
    send(8'hF0, 1'b0);
    send(8'hC9, 1'b0);
    send(8'hFA, 1'b0);
    idle(4);
    `CHK("store", 1'b1, o_storage_half)
    `CHK("fetch", 1'b0, o_fetch_half)
    send(8'hED, 1'b0);
    idle(4);
    `CHK("drive", 2'h1, o_drive_sel)
    `CHK("sub", 3'h0, o_sub_counter)
    `CHK("store", 1'b1, o_storage_half)
    send(8'hE5, 1'b0);
    idle(4);
    `CHK("sub", 3'h5, o_sub_counter)
    send(8'hA7, 1'b0);
    idle(4);
    `CHK("pointer", 6'h27, o_ram_pointer)
    // Static data: five writes, then wrap to the next subaddress
    send(8'hE0, 1'b0);
    send(8'h00, 1'b0);
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      if (i < 5) exp_q.push_back({1'b1, 6'(i * 8), d});
      send(d, 1'b0);
    end
    idle(8);
    `CHK("sub", 3'h1, o_sub_counter)
    `CHK("pointer", 6'h08, o_ram_pointer)
    `CHK("writes left", 0, exp_q.size())
    // Fill the FIFO while the RAM stalls, then drain with random stalls
    i_ram_ready <= 1'b0;
    send(8'hFC, 1'b1);
    n = 1;
    repeat (20) begin @(posedge i_clk); if (o_byte_ready === 1'b1) n++; end
    `CHK("fifo fill", 16, n)
    idle(1);
    repeat (40) begin i_ram_ready <= 1'($random(seed)); @(posedge i_clk); end
    i_ram_ready <= 1'b1;
    idle(20);
    `CHK("drained", 1'b1, o_byte_ready)
    `CHK("drive", 2'h1, o_drive_sel)
    // 1:4; sibling pulls on the display clock edge ending phase 0, device must jump to phase 3 long before its own
    send(8'hC8, 1'b1);
    idle(2);
    n = 0;
    while (o_align_oe !== 1'b1 && n < 100) begin @(posedge i_clk); n++; end
    while (o_align_oe !== 1'b0 && n < 200) begin @(posedge i_clk); n++; end
    pull <= 1'b1;
    @(posedge i_clk);
    pull <= 1'b0;
    repeat (10) @(posedge i_clk);
    `CHK("align oe", 1'b1, o_align_oe)
    `CHK("phase", 2'h3, o_bp_phase)
    // 1:4 data: step 2 from 38 wraps to the next subaddress; storage half unused
    send(8'hE0, 1'b1);
    send(8'h26, 1'b0);
    d = 8'($random(seed));
    exp_q.push_back({1'b0, 6'h26, d});
    send(d, 1'b0);
    send(8'($random(seed)), 1'b0);
    idle(8);
    `CHK("pointer", 6'h02, o_ram_pointer)
    `CHK("sub", 3'h1, o_sub_counter)
    `CHK("writes left", 0, exp_q.size())
    idle(10);
    tally_and_finish();
  end
endmodule // lcdc_top_tb
